/* hdl/timer_oe_pkg.sv */
package timer_oe_pkg;

  // ****************************************************************
  // Register map, byte addresses on the 32-bit register bus
  // ****************************************************************
  localparam logic [11:0] OFS_ENABLE_LOW = 12'h000;
  localparam logic [11:0] OFS_ENABLE_HIGH = 12'h004;
  localparam logic [11:0] OFS_CAPTURE_CFG = 12'h008;
  localparam logic [11:0] OFS_PIN_STATUS = 12'h00c;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [7:0] RST_ENABLE_LOW = 8'h00;
  localparam logic [7:0] RST_ENABLE_HIGH = 8'h00;
  localparam logic [7:0] RST_CAPTURE_CFG = 8'h00;

  // ****************************************************************
  // Field positions inside an enable register (lsb of each pair)
  // ****************************************************************
  localparam int POS_GENERAL_A = 0;
  localparam int POS_GENERAL_B = 2;
  localparam int POS_DEDICATED_A = 4;
  localparam int POS_DEDICATED_B = 6;

  // Capture-edge pairs inside the capture configuration register
  localparam int POS_EDGE_A = 0;
  localparam int POS_EDGE_B = 2;
  localparam int POS_EDGE_C = 4;
  localparam int POS_EDGE_D = 6;

  // Status register layout
  localparam int POS_STAT_ENABLE = 0;
  localparam int POS_STAT_LEVEL = 8;

  // ****************************************************************
  // Two-bit gate codes
  // ****************************************************************
  localparam logic [1:0] GATE_OFF = 2'b00;
  localparam logic [1:0] GATE_DRIVE_LOW = 2'b01;
  localparam logic [1:0] GATE_DRIVE_HIGH = 2'b10;
  localparam logic [1:0] GATE_UNDEFINED = 2'b11;

  // ****************************************************************
  // Bus responses
  // ****************************************************************
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

endpackage : timer_oe_pkg

/* hdl/gate_bus_if.sv */
`timescale 1ns/1ns
`default_nettype none

// Carries the gate settings in and the pin state out of the gate bank
interface gate_bus_if #(
  parameter int N = 8
);
  logic [2*N-1:0] field;
  logic [N-1:0] capture;
  logic [N-1:0] match;
  logic [N-1:0] level;
  logic [N-1:0] enable;

  modport ctrl (
    output field,
    output capture,
    output match,
    input level,
    input enable
  );

  modport bank (
    input field,
    input capture,
    input match,
    output level,
    output enable
  );
endinterface : gate_bus_if

`default_nettype wire

/* hdl/compare_output_gate.sv */
`timescale 1ns/1ns
`default_nettype none

module compare_output_gate (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic [1:0] field,
  input wire logic capture,
  input wire logic match,
  output logic level,
  output logic enable
);

  logic level_reg, level_next;
  logic enable_reg, enable_next;

  // Next pin state from gate code, capture mode and match
  always_comb begin
    level_next = level_reg;
    enable_next = enable_reg;
    if (capture) begin
      enable_next = 1'b0;
    end else begin
      unique case (field)
        timer_oe_pkg::GATE_OFF: begin
          enable_next = 1'b0;
        end
        timer_oe_pkg::GATE_DRIVE_LOW: begin
          enable_next = 1'b1;
          if (match) begin
            level_next = 1'b0;
          end
        end
        timer_oe_pkg::GATE_DRIVE_HIGH: begin
          enable_next = 1'b1;
          if (match) begin
            level_next = 1'b1;
          end
        end
        timer_oe_pkg::GATE_UNDEFINED: begin
          // Code is unspecified; freezing the pin is the least surprising
          level_next = level_reg;
        end
      endcase
    end
  end

  // Pin state registers, disabled and low from reset
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      level_reg <= 1'b0;
      enable_reg <= 1'b0;
    end else begin
      level_reg <= level_next;
      enable_reg <= enable_next;
    end
  end

  assign level = level_reg;
  assign enable = enable_reg;

endmodule : compare_output_gate

`default_nettype wire

/* hdl/compare_gate_bank.sv */
`timescale 1ns/1ns
`default_nettype none

module compare_gate_bank #(
  parameter int N = 8
) (
  input wire logic sys_clk,
  input wire logic arst_n,
  gate_bus_if.bank gates
);

  // One gate per compare-match output
  for (genvar i = 0; i < N; i++) begin : g_gate
    compare_output_gate u_gate (
      .sys_clk(sys_clk),
      .arst_n(arst_n),
      .field(gates.field[2*i+1:2*i]),
      .capture(gates.capture[i]),
      .match(gates.match[i]),
      .level(gates.level[i]),
      .enable(gates.enable[i])
    );
  end

endmodule : compare_gate_bank

`default_nettype wire

/* hdl/timer_compare_output_enable.sv */
// Operation
// - Eight-bit read/write enable register, resets to zero
// - First channel has two enable registers
// - Bits 7:6 gate second dedicated compare output
// - Bits 5:4 gate first dedicated compare output
// - Bits 3:2 gate second general register output
// - Bits 1:0 gate first general register output
// - Capture on second general register suppresses output
// - Capture on first general register suppresses output
//
// The implementer's own choices: register access over AXI4-Lite and the register offsets.
`timescale 1ns/1ns
`default_nettype none

module timer_compare_output_enable #(
  parameter int ADDR_W = 12
) (
  input wire logic sys_clk,
  input wire logic arst_n,
  // AXI4-Lite write address
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Compare-match pulses from the counter, same clock
  input wire logic [7:0] cmp_match,
  // Compare output pins
  output logic [7:0] cmp_out_level,
  output logic [7:0] cmp_out_en
);

  // ****************************************************************
  // Write channel state
  // ****************************************************************
  logic aw_hold_reg, aw_hold_next;
  logic [ADDR_W-1:0] aw_addr_reg, aw_addr_next;
  logic w_hold_reg, w_hold_next;
  logic [7:0] w_data_reg, w_data_next;
  logic w_strb_reg, w_strb_next;
  logic awready_reg, awready_next;
  logic wready_reg, wready_next;
  logic bvalid_reg, bvalid_next;
  logic [1:0] bresp_reg, bresp_next;
  logic do_write;

  // ****************************************************************
  // Read channel state
  // ****************************************************************
  logic arready_reg, arready_next;
  logic rvalid_reg, rvalid_next;
  logic [31:0] rdata_reg, rdata_next;
  logic [1:0] rresp_reg, rresp_next;

  // ****************************************************************
  // Software registers
  // ****************************************************************
  logic [7:0] compare_output_enable_low_reg, compare_output_enable_low_next;
  logic [7:0] compare_output_enable_high_reg, compare_output_enable_high_next;
  logic [7:0] capture_cfg_reg, capture_cfg_next;

  gate_bus_if #(.N(8)) gates ();

  // ****************************************************************
  // Address decode
  // ****************************************************************
  logic wr_sel_low, wr_sel_high, wr_sel_cap, wr_sel_stat;
  logic rd_sel_low, rd_sel_high, rd_sel_cap, rd_sel_stat;
  logic [31:0] status_word;

  // Held write address, decoded once for both the store and the response
  always_comb begin
    wr_sel_low = 1'b0;
    wr_sel_high = 1'b0;
    wr_sel_cap = 1'b0;
    wr_sel_stat = 1'b0;
    unique case (aw_addr_reg)
      timer_oe_pkg::OFS_ENABLE_LOW: wr_sel_low = 1'b1;
      timer_oe_pkg::OFS_ENABLE_HIGH: wr_sel_high = 1'b1;
      timer_oe_pkg::OFS_CAPTURE_CFG: wr_sel_cap = 1'b1;
      timer_oe_pkg::OFS_PIN_STATUS: wr_sel_stat = 1'b1;
      default: wr_sel_stat = 1'b0;
    endcase
  end

  // Live read address; the answer is registered at the edge that takes it
  always_comb begin
    rd_sel_low = 1'b0;
    rd_sel_high = 1'b0;
    rd_sel_cap = 1'b0;
    rd_sel_stat = 1'b0;
    unique case (s_axi_araddr)
      timer_oe_pkg::OFS_ENABLE_LOW: rd_sel_low = 1'b1;
      timer_oe_pkg::OFS_ENABLE_HIGH: rd_sel_high = 1'b1;
      timer_oe_pkg::OFS_CAPTURE_CFG: rd_sel_cap = 1'b1;
      timer_oe_pkg::OFS_PIN_STATUS: rd_sel_stat = 1'b1;
      default: rd_sel_stat = 1'b0;
    endcase
  end

  // Status word: drive enables in the low byte, pin levels above them
  always_comb begin
    status_word = 32'h0000_0000;
    status_word[timer_oe_pkg::POS_STAT_ENABLE +: 8] = gates.enable;
    status_word[timer_oe_pkg::POS_STAT_LEVEL +: 8] = gates.level;
  end

  // Address and data are taken independently, in either order
  always_comb begin
    aw_hold_next = aw_hold_reg;
    aw_addr_next = aw_addr_reg;
    w_hold_next = w_hold_reg;
    w_data_next = w_data_reg;
    w_strb_next = w_strb_reg;
    bvalid_next = bvalid_reg;
    bresp_next = bresp_reg;
    do_write = aw_hold_reg && w_hold_reg && !bvalid_reg;
    if (s_axi_awvalid && awready_reg) begin
      aw_hold_next = 1'b1;
      aw_addr_next = s_axi_awaddr;
    end
    if (s_axi_wvalid && wready_reg) begin
      w_hold_next = 1'b1;
      w_data_next = s_axi_wdata[7:0];
      w_strb_next = s_axi_wstrb[0];
    end
    if (do_write) begin
      aw_hold_next = 1'b0;
      w_hold_next = 1'b0;
      bvalid_next = 1'b1;
      if (wr_sel_low || wr_sel_high || wr_sel_cap || wr_sel_stat) begin
        bresp_next = timer_oe_pkg::RESP_OKAY;
      end else begin
        bresp_next = timer_oe_pkg::RESP_SLVERR;
      end
    end else if (bvalid_reg && s_axi_bready) begin
      bvalid_next = 1'b0;
    end
    // A held item blocks its own channel until the response is taken
    awready_next = !aw_hold_next && !bvalid_next;
    wready_next = !w_hold_next && !bvalid_next;
  end

  // Write channel registers
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      aw_hold_reg <= 1'b0;
      aw_addr_reg <= '0;
      w_hold_reg <= 1'b0;
      w_data_reg <= 8'h00;
      w_strb_reg <= 1'b0;
      awready_reg <= 1'b0;
      wready_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      bresp_reg <= timer_oe_pkg::RESP_OKAY;
    end else begin
      aw_hold_reg <= aw_hold_next;
      aw_addr_reg <= aw_addr_next;
      w_hold_reg <= w_hold_next;
      w_data_reg <= w_data_next;
      w_strb_reg <= w_strb_next;
      awready_reg <= awready_next;
      wready_reg <= wready_next;
      bvalid_reg <= bvalid_next;
      bresp_reg <= bresp_next;
    end
  end

  // Register updates; only byte lane 0 carries data, status is read-only
  always_comb begin
    compare_output_enable_low_next = compare_output_enable_low_reg;
    compare_output_enable_high_next = compare_output_enable_high_reg;
    capture_cfg_next = capture_cfg_reg;
    if (do_write && w_strb_reg) begin
      if (wr_sel_low) begin
        compare_output_enable_low_next = w_data_reg;
      end
      if (wr_sel_high) begin
        compare_output_enable_high_next = w_data_reg;
      end
      if (wr_sel_cap) begin
        capture_cfg_next = w_data_reg;
      end
    end
  end

  // All gates start disabled because every field clears at reset
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      compare_output_enable_low_reg <= timer_oe_pkg::RST_ENABLE_LOW;
      compare_output_enable_high_reg <= timer_oe_pkg::RST_ENABLE_HIGH;
      capture_cfg_reg <= timer_oe_pkg::RST_CAPTURE_CFG;
    end else begin
      compare_output_enable_low_reg <= compare_output_enable_low_next;
      compare_output_enable_high_reg <= compare_output_enable_high_next;
      capture_cfg_reg <= capture_cfg_next;
    end
  end

  // Read path: one request at a time, data one cycle after the address
  always_comb begin
    rvalid_next = rvalid_reg;
    rdata_next = rdata_reg;
    rresp_next = rresp_reg;
    if (s_axi_arvalid && arready_reg) begin
      rvalid_next = 1'b1;
      rdata_next = 32'h0000_0000;
      rresp_next = timer_oe_pkg::RESP_OKAY;
      if (rd_sel_low) begin
        rdata_next[7:0] = compare_output_enable_low_reg;
      end else if (rd_sel_high) begin
        rdata_next[7:0] = compare_output_enable_high_reg;
      end else if (rd_sel_cap) begin
        rdata_next[7:0] = capture_cfg_reg;
      end else if (rd_sel_stat) begin
        rdata_next = status_word;
      end else begin
        rresp_next = timer_oe_pkg::RESP_SLVERR;
      end
    end else if (rvalid_reg && s_axi_rready) begin
      rvalid_next = 1'b0;
    end
    arready_next = !rvalid_next;
  end

  // Read channel registers
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      rresp_reg <= timer_oe_pkg::RESP_OKAY;
    end else begin
      arready_reg <= arready_next;
      rvalid_reg <= rvalid_next;
      rdata_reg <= rdata_next;
      rresp_reg <= rresp_next;
    end
  end

  // ****************************************************************
  // Gate wiring
  // ****************************************************************
  // Gates 0..3 from the low register, 4..7 from the high register
  assign gates.field[1:0] = compare_output_enable_low_reg[timer_oe_pkg::POS_GENERAL_A +: 2];
  assign gates.field[3:2] = compare_output_enable_low_reg[timer_oe_pkg::POS_GENERAL_B +: 2];
  assign gates.field[5:4] = compare_output_enable_low_reg[timer_oe_pkg::POS_DEDICATED_A +: 2];
  assign gates.field[7:6] = compare_output_enable_low_reg[timer_oe_pkg::POS_DEDICATED_B +: 2];
  assign gates.field[15:8] = compare_output_enable_high_reg;

  // Any nonzero edge select puts a general register in capture mode
  assign gates.capture[0] = |capture_cfg_reg[timer_oe_pkg::POS_EDGE_A +: 2];
  assign gates.capture[1] = |capture_cfg_reg[timer_oe_pkg::POS_EDGE_B +: 2];
  assign gates.capture[3:2] = 2'b00; // Dedicated registers never capture
  assign gates.capture[4] = |capture_cfg_reg[timer_oe_pkg::POS_EDGE_C +: 2];
  assign gates.capture[5] = |capture_cfg_reg[timer_oe_pkg::POS_EDGE_D +: 2];
  assign gates.capture[7:6] = 2'b00;
  assign gates.match = cmp_match;

  // Gate bank holds the pin flip-flops
  compare_gate_bank #(.N(8)) u_bank (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .gates(gates.bank)
  );

  // ****************************************************************
  // Outputs, each straight from a flip-flop
  // ****************************************************************
  // Write channel
  assign s_axi_awready = awready_reg;
  assign s_axi_wready = wready_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;

  // Read channel
  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;

  // Pins come straight from the gate flip-flops
  assign cmp_out_level = gates.level;
  assign cmp_out_en = gates.enable;

endmodule : timer_compare_output_enable

`default_nettype wire

/* bench/timer_oe_sva.sv */
`timescale 1ns/1ns
`default_nettype none

// ********
// Port checks for the compare output block
// ********
module timer_oe_sva (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [7:0] cmp_match,
  input wire logic [7:0] cmp_out_level,
  input wire logic [7:0] cmp_out_en
);
  // One clock domain, reset kills every check
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!arst_n);

  // Write answer comes exactly two edges after both halves
  property p_wr_lat;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> !s_axi_bvalid ##1 s_axi_bvalid;
  endproperty
  a_wr_lat: assert property (p_wr_lat) else $error("write answer timing wrong");

  // No new write taken while an answer is pending
  property p_wr_block;
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
  endproperty
  a_wr_block: assert property (p_wr_block) else $error("write accepted during answer");

  // Answers drop once taken
  property p_b_done;
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
  endproperty
  a_b_done: assert property (p_b_done) else $error("write answer repeated");

  property p_rd_lat;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready;
  endproperty
  a_rd_lat: assert property (p_rd_lat) else $error("read answer timing wrong");

  property p_r_done;
    s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid;
  endproperty
  a_r_done: assert property (p_r_done) else $error("read answer repeated");

  // Upper data zero; refused reads return zero
  property p_rdata;
    s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000 && (s_axi_rresp == 2'b00 || s_axi_rdata == 32'h0000_0000);
  endproperty
  a_rdata: assert property (p_rdata) else $error("read data out of range");

  // Enables move only as a result of a register write
  property p_en_cause;
    $changed(cmp_out_en) |-> $past(s_axi_bvalid);
  endproperty
  a_en_cause: assert property (p_en_cause) else $error("enable moved without write");

  // A pin level moves only on its own match
  property p_lvl_cause;
    ((cmp_out_level ^ $past(cmp_out_level)) & ~$past(cmp_match)) == 8'h00;
  endproperty
  a_lvl_cause: assert property (p_lvl_cause) else $error("level moved without match");

  // A disabled pin never changes level
  property p_lvl_off;
    ((cmp_out_level ^ $past(cmp_out_level)) & ~cmp_out_en) == 8'h00;
  endproperty
  a_lvl_off: assert property (p_lvl_off) else $error("disabled pin changed");
endmodule : timer_oe_sva

`default_nettype wire

/* bench/tb.sv */
`timescale 1ns/1ns
`default_nettype none

bind timer_compare_output_enable timer_oe_sva u_sva (
  .sys_clk(sys_clk),
  .arst_n(arst_n),
  .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata),
  .s_axi_rresp(s_axi_rresp),
  .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready),
  .cmp_match(cmp_match),
  .cmp_out_level(cmp_out_level),
  .cmp_out_en(cmp_out_en)
);

module tb;
  localparam logic [1:0] okay = timer_oe_pkg::RESP_OKAY;
  localparam logic [1:0] serr = timer_oe_pkg::RESP_SLVERR;
  logic sys_clk, arst_n;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [2:0] s_axi_awprot, s_axi_arprot;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready;
  logic [7:0] cmp_match, cmp_out_level, cmp_out_en, lvl, v;
  int n_fail, n_tests, cyc, b;

  timer_compare_output_enable uut (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awprot(s_axi_awprot),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arprot(s_axi_arprot),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .cmp_match(cmp_match),
    .cmp_out_level(cmp_out_level),
    .cmp_out_en(cmp_out_en)
  );

  // ********
  // Clock, guard and report
  // ********
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  // Whole run is a few hundred cycles, so 3000 means a hang
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_fail++;
      close_out();
    end
  end

  task automatic close_out;
    $display("checks %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : close_out

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // ********
  // Bus tasks
  // ********
  // Each channel is released only at the edge that takes it
  task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] er);
    @(posedge sys_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h00_0000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    chk("bresp", 32'(s_axi_bresp), 32'(er));
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
    @(posedge sys_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    chk("rdata", s_axi_rdata, ed);
    chk("rresp", 32'(s_axi_rresp), 32'(er));
  endtask : rd

  // One-cycle match pulse, then let the pin flop settle
  task automatic pulse(input logic [7:0] m);
    @(posedge sys_clk);
    cmp_match <= m;
    @(posedge sys_clk);
    cmp_match <= 8'h00;
    repeat (2) @(posedge sys_clk);
  endtask : pulse

  // ********
  // Test sequence
  // ********
  initial begin
    arst_n = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_awprot, s_axi_arprot} = 30'h0000_0000;
    s_axi_wdata = 32'h0000_0000;
    s_axi_wstrb = 4'h1;
    cmp_match = 8'h00;
    lvl = 8'h00;
    repeat (4) @(posedge sys_clk);
    arst_n <= 1'b1;
    rd(12'h000, 32'h0000_0000, okay);
    rd(12'h004, 32'h0000_0000, okay);
    chk("en_rst", cmp_out_en, 32'h0000_0000);
    wr(12'h000, 8'ha5, okay);
    rd(12'h000, 32'h0000_00a5, okay);
    wr(12'h004, 8'h5a, okay);
    rd(12'h004, 32'h0000_005a, okay);
    wr(12'h010, 8'hff, serr);
    rd(12'h010, 32'h0000_0000, serr);
    // Every field of both registers, drive high then low; codes 01 and 10 only
    for (int r = 0; r < 2; r++) begin
      wr(12'(4 - 4 * r), 8'h00, okay);
      for (int p = 0; p < 4; p++) begin
        for (int c = 2; c > 0; c--) begin
          b = 4 * r + p;
          v = 8'(c) << (2 * p);
          wr(12'(4 * r), v, okay);
          pulse(8'hff);
          lvl[b] = (c == 2);
          chk("en", cmp_out_en, 32'(8'h01 << b));
          chk("level", cmp_out_level, lvl);
        end
      end
    end
    // Capture mode on each general register of the low register hides its output
    wr(12'h004, 8'h00, okay);
    wr(12'h000, 8'h0a, okay);
    wr(12'h008, 8'h01, okay);
    pulse(8'h03);
    chk("cap_a_en", cmp_out_en, 32'h0000_0002);
    chk("cap_a_lvl", cmp_out_level, 32'h0000_0002);
    wr(12'h000, 8'h06, okay);
    wr(12'h008, 8'h08, okay);
    pulse(8'h03);
    chk("cap_b_en", cmp_out_en, 32'h0000_0001);
    chk("cap_b_lvl", cmp_out_level, 32'h0000_0003);
    // Capture on the high register's first general gate
    wr(12'h004, 8'h0a, okay);
    wr(12'h008, 8'h10, okay);
    pulse(8'h33);
    chk("cap_c_en", cmp_out_en, 32'h0000_0023);
    chk("cap_c_lvl", cmp_out_level, 32'h0000_0021);
    // Disabled pins keep their levels; status writes are ignored
    wr(12'h008, 8'h00, okay);
    wr(12'h004, 8'h00, okay);
    wr(12'h000, 8'h00, okay);
    wr(12'h00c, 8'hff, okay);
    pulse(8'hff);
    chk("off_en", cmp_out_en, 32'h0000_0000);
    chk("off_lvl", cmp_out_level, 32'h0000_0021);
    rd(12'h00c, 32'h0000_2100, okay);
    close_out();
  end
endmodule : tb

`default_nettype wire
